// ==== src/pxb_map.svh ====
/*
 * Constants of the port crossbar: register offsets, reset values, field
 * positions and function indices. Assumes an includer that wants them.
 */
// Function
// - three eight-bit ports, 24 pins, each GPIO, analog or routed function.
// - enabled functions walk priority order, each taking lowest free pin.
// - UART transmit always on port 0 bit 4, receive on bit 5.
// - skip-marked pins are passed over like already occupied pins.
// - SMBus enable allocates SDA and SCL; UART enable both its lines.
// - remaining pins stay ordinary port I/O.
// - SPI slave-select gets a pin only in four-wire mode.
// - port register reads the live pin level whatever is routed there.
// - output-mode bit picks open-drain or push-pull; SDA/SCL always open-drain.
// - pullup-disable at 0 enables weak pullups on open-drain pins only.
// - pullup off on pins driving low and on analog pins.
// - input-mode 1 digital, 0 analog; analog kills pullup, driver, receiver.
// - reset makes every pin a digital input.
// - crossbar disabled keeps all digital pins plain port inputs.
// - output drivers stay off until the crossbar is enabled.
// - timer-array field routes 0 to 6 capture outputs; code 111 reserved.
`ifndef PXB_MAP_SVH
`define PXB_MAP_SVH
`define PXB_NPINS 24
`define PXB_NFUNC 22
`define PXB_A_RSL 8'h00
`define PXB_A_RSH 8'h04
`define PXB_A_PORT 8'h08
`define PXB_A_INMODE 8'h0c
`define PXB_A_OUTMODE 8'h10
`define PXB_A_SKIP 8'h14
`define PXB_A_SSM 8'h18
`define PXB_RST_PINS_ONE 24'hffffff
`define PXB_RST_PINS_ZERO 24'h000000
`define PXB_RST_BYTE 8'h00
`define PXB_RST_SSM 2'h0
`define PXB_SSM_3WIRE 2'h0
`define PXB_CEX_RSVD 3'h7
`define PXB_B_UART 0
`define PXB_B_SPI 1
`define PXB_B_SMB 2
`define PXB_B_SYSCK 3
`define PXB_B_CP0 4
`define PXB_B_CP0A 5
`define PXB_B_CP1 6
`define PXB_B_CP1A 7
`define PXB_B_ECI 3
`define PXB_B_T0 4
`define PXB_B_T1 5
`define PXB_B_XBAR 6
`define PXB_B_PUD 7
`define PXB_B_CNT_HI 2
`define PXB_B_CNT_LO 0
`define PXB_NCEX 6
`define PXB_F_TX 5'h00
`define PXB_F_RX 5'h01
`define PXB_F_SCK 5'h02
`define PXB_F_MISO 5'h03
`define PXB_F_MOSI 5'h04
`define PXB_F_NSS 5'h05
`define PXB_F_SDA 5'h06
`define PXB_F_SCL 5'h07
`define PXB_F_CP0 8
`define PXB_F_CP0A 9
`define PXB_F_CP1 10
`define PXB_F_CP1A 11
`define PXB_F_SYSCK 12
`define PXB_F_CEX0 13
`define PXB_F_ECI 19
`define PXB_F_FIRST 2
`define PXB_P_TX 4
`define PXB_P_RX 5
`endif

// ==== src/pxb_pkg.sv ====
/*
 * Types shared by the port crossbar. Assumes pxb_map.svh for the sizes.
 */
`include "pxb_map.svh"
package pxb_pkg;
  typedef logic [`PXB_NPINS-1:0] pxb_pins_t;
  typedef logic [4:0] pxb_fidx_t;
  typedef logic [`PXB_NFUNC-1:0] pxb_funcs_t;
endpackage

// ==== src/pxb_crossbar.sv ====
/*
 * Priority port crossbar with pin configuration, reached over APB.
 * Assumes peripherals present per-function output data and drive enables,
 * and a pad ring that resolves o_pin_out/o_pin_oe_n/o_pullup_en into pins.
 */
`timescale 1ns/1ps
`include "pxb_map.svh"
module pxb_crossbar
  import pxb_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire pxb_pins_t i_pin_in,
  output pxb_pins_t o_pin_out,
  output pxb_pins_t o_pin_oe_n,
  output pxb_pins_t o_pullup_en,
  output pxb_pins_t o_pin_analog,
  input wire pxb_funcs_t i_func_out,
  input wire pxb_funcs_t i_func_oe,
  output pxb_funcs_t o_func_in
);

  ////////////////////////////////////////////////////////////////////////////
  // register file and APB slave

  logic [7:0] route_select_low_ff, nxt_route_select_low;
  logic [7:0] route_select_high_ff, nxt_route_select_high;
  pxb_pins_t latch_ff, nxt_latch;
  pxb_pins_t pin_input_mode_ff, nxt_pin_input_mode;
  pxb_pins_t pin_output_mode_ff, nxt_pin_output_mode;
  pxb_pins_t pin_skip_mask_ff, nxt_pin_skip_mask;
  logic [1:0] slave_select_mode_ff, nxt_slave_select_mode;
  logic [31:0] nxt_prdata;
  logic nxt_pready, nxt_pslverr;
  logic hit, wr_take;
  logic [31:0] rd_mux;
  pxb_pins_t lvl_ff, nxt_lvl;
  pxb_pins_t sync1_ff, sync2_ff, sync3_ff;

  always_comb
  begin
    hit = 1'b1;
    rd_mux = 32'h0;
    case (i_paddr)
      `PXB_A_RSL: rd_mux = {24'h0, route_select_low_ff};
      `PXB_A_RSH: rd_mux = {24'h0, route_select_high_ff};
      `PXB_A_PORT: rd_mux = {8'h0, lvl_ff & pin_input_mode_ff};
      `PXB_A_INMODE: rd_mux = {8'h0, pin_input_mode_ff};
      `PXB_A_OUTMODE: rd_mux = {8'h0, pin_output_mode_ff};
      `PXB_A_SKIP: rd_mux = {8'h0, pin_skip_mask_ff};
      `PXB_A_SSM: rd_mux = {30'h0, slave_select_mode_ff};
      default: hit = 1'b0;
    endcase
    // one wait state: data and error are registered alongside ready
    nxt_pready = i_psel & i_penable & ~o_pready;
    nxt_prdata = (nxt_pready & ~i_pwrite) ? rd_mux : 32'h0;
    nxt_pslverr = nxt_pready & ~hit;
    wr_take = i_psel & i_penable & o_pready & i_pwrite & hit;
    nxt_route_select_low = route_select_low_ff;
    nxt_route_select_high = route_select_high_ff;
    nxt_latch = latch_ff;
    nxt_pin_input_mode = pin_input_mode_ff;
    nxt_pin_output_mode = pin_output_mode_ff;
    nxt_pin_skip_mask = pin_skip_mask_ff;
    nxt_slave_select_mode = slave_select_mode_ff;
    if (wr_take)
    begin
      case (i_paddr)
        `PXB_A_RSL: nxt_route_select_low = i_pwdata[7:0];
        `PXB_A_RSH: nxt_route_select_high = i_pwdata[7:0];
        `PXB_A_PORT: nxt_latch = i_pwdata[23:0];
        `PXB_A_INMODE: nxt_pin_input_mode = i_pwdata[23:0];
        `PXB_A_OUTMODE: nxt_pin_output_mode = i_pwdata[23:0];
        `PXB_A_SKIP: nxt_pin_skip_mask = i_pwdata[23:0];
        `PXB_A_SSM: nxt_slave_select_mode = i_pwdata[1:0];
        default: nxt_latch = latch_ff;
      endcase
    end
    // a level counts only once the last two stages agree
    nxt_lvl = (sync2_ff & ~(sync2_ff ^ sync3_ff)) | (lvl_ff & (sync2_ff ^ sync3_ff));
  end

  always_ff @(posedge i_ref_clk)
  begin
    sync1_ff <= i_pin_in;
    sync2_ff <= sync1_ff;
    sync3_ff <= sync2_ff;
    if (i_rst)
    begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
      route_select_low_ff <= `PXB_RST_BYTE;
      route_select_high_ff <= `PXB_RST_BYTE;
      latch_ff <= `PXB_RST_PINS_ONE;
      pin_input_mode_ff <= `PXB_RST_PINS_ONE;
      pin_output_mode_ff <= `PXB_RST_PINS_ZERO;
      pin_skip_mask_ff <= `PXB_RST_PINS_ZERO;
      slave_select_mode_ff <= `PXB_RST_SSM;
      lvl_ff <= `PXB_RST_PINS_ONE;
    end
    else
    begin
      o_pready <= nxt_pready;
      o_prdata <= nxt_prdata;
      o_pslverr <= nxt_pslverr;
      route_select_low_ff <= nxt_route_select_low;
      route_select_high_ff <= nxt_route_select_high;
      latch_ff <= nxt_latch;
      pin_input_mode_ff <= nxt_pin_input_mode;
      pin_output_mode_ff <= nxt_pin_output_mode;
      pin_skip_mask_ff <= nxt_pin_skip_mask;
      slave_select_mode_ff <= nxt_slave_select_mode;
      lvl_ff <= nxt_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // allocation and pin drive, recomputed every cycle

  logic router_enable, pullup_disable;
  pxb_funcs_t fen;
  pxb_pins_t taken, a_vld, is_i2c, nxt_i2c_ff, i2c_ff;
  pxb_fidx_t a_fn [`PXB_NPINS];
  logic [2:0] cex_cnt;
  logic done, od, dat, drv, drv_on;
  pxb_pins_t nxt_pin_out, nxt_pin_oe_n, nxt_pullup_en, nxt_pin_analog;
  pxb_funcs_t nxt_func_in;

  always_comb
  begin
    router_enable = route_select_high_ff[`PXB_B_XBAR];
    pullup_disable = route_select_high_ff[`PXB_B_PUD];
    cex_cnt = route_select_high_ff[`PXB_B_CNT_HI:`PXB_B_CNT_LO];
    fen = '0;
    fen[`PXB_F_TX] = route_select_low_ff[`PXB_B_UART];
    fen[`PXB_F_RX] = route_select_low_ff[`PXB_B_UART];
    fen[`PXB_F_SCK] = route_select_low_ff[`PXB_B_SPI];
    fen[`PXB_F_MISO] = route_select_low_ff[`PXB_B_SPI];
    fen[`PXB_F_MOSI] = route_select_low_ff[`PXB_B_SPI];
    fen[`PXB_F_NSS] = route_select_low_ff[`PXB_B_SPI]
      & (slave_select_mode_ff != `PXB_SSM_3WIRE);
    fen[`PXB_F_SDA] = route_select_low_ff[`PXB_B_SMB];
    fen[`PXB_F_SCL] = route_select_low_ff[`PXB_B_SMB];
    fen[`PXB_F_CP0] = route_select_low_ff[`PXB_B_CP0];
    fen[`PXB_F_CP0A] = route_select_low_ff[`PXB_B_CP0A];
    fen[`PXB_F_CP1] = route_select_low_ff[`PXB_B_CP1];
    fen[`PXB_F_CP1A] = route_select_low_ff[`PXB_B_CP1A];
    fen[`PXB_F_SYSCK] = route_select_low_ff[`PXB_B_SYSCK];
    // reserved count routes nothing
    for (int k = 0; k < `PXB_NCEX; k++)
      fen[`PXB_F_CEX0 + k] = (cex_cnt != `PXB_CEX_RSVD) && (3'(k) < cex_cnt);
    fen[`PXB_F_ECI] = route_select_high_ff[`PXB_B_ECI];
    fen[`PXB_F_ECI + 1] = route_select_high_ff[`PXB_B_T0];
    fen[`PXB_F_ECI + 2] = route_select_high_ff[`PXB_B_T1];
    taken = pin_skip_mask_ff;
    a_vld = '0;
    for (int p = 0; p < `PXB_NPINS; p++)
      a_fn[p] = `PXB_F_TX;
    if (fen[`PXB_F_TX])
    begin
      a_vld[`PXB_P_TX] = 1'b1;
      a_vld[`PXB_P_RX] = 1'b1;
      a_fn[`PXB_P_RX] = `PXB_F_RX;
      taken[`PXB_P_TX] = 1'b1;
      taken[`PXB_P_RX] = 1'b1;
    end
    for (int f = `PXB_F_FIRST; f < `PXB_NFUNC; f++)
    begin
      done = ~fen[f];
      for (int p = 0; p < `PXB_NPINS; p++)
      begin
        if (!done && !taken[p])
        begin
          a_vld[p] = 1'b1;
          a_fn[p] = 5'(f);
          taken[p] = 1'b1;
          done = 1'b1;
        end
      end
    end
    nxt_func_in = '1;
    od = 1'b0;
    dat = 1'b0;
    drv = 1'b0;
    drv_on = 1'b0;
    for (int p = 0; p < `PXB_NPINS; p++)
    begin
      is_i2c[p] = a_vld[p] && (a_fn[p] == `PXB_F_SDA || a_fn[p] == `PXB_F_SCL);
      od = ~pin_output_mode_ff[p] | is_i2c[p];
      if (router_enable && a_vld[p])
      begin
        dat = i_func_out[a_fn[p]];
        drv = i_func_oe[a_fn[p]];
        nxt_func_in[a_fn[p]] = lvl_ff[p] & pin_input_mode_ff[p];
      end
      else
      begin
        dat = latch_ff[p];
        drv = 1'b1;
      end
      // drivers need both the crossbar and a digital pin
      drv_on = router_enable & pin_input_mode_ff[p] & drv & (~od | ~dat);
      nxt_pin_oe_n[p] = ~drv_on;
      nxt_pin_out[p] = drv_on & dat;
      nxt_pullup_en[p] = pin_input_mode_ff[p] & od & ~pullup_disable
        & ~(drv_on & ~dat);
      nxt_pin_analog[p] = ~pin_input_mode_ff[p];
    end
    nxt_i2c_ff = is_i2c;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      o_pin_out <= `PXB_RST_PINS_ZERO;
      o_pin_oe_n <= `PXB_RST_PINS_ONE;
      o_pullup_en <= `PXB_RST_PINS_ZERO;
      o_pin_analog <= `PXB_RST_PINS_ZERO;
      o_func_in <= '1;
      i2c_ff <= `PXB_RST_PINS_ZERO;
    end
    else
    begin
      o_pin_out <= nxt_pin_out;
      o_pin_oe_n <= nxt_pin_oe_n;
      o_pullup_en <= nxt_pullup_en;
      o_pin_analog <= nxt_pin_analog;
      o_func_in <= nxt_func_in;
      i2c_ff <= nxt_i2c_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  property p_uart_fixed;
    (router_enable && route_select_low_ff[`PXB_B_UART] && i_func_oe[`PXB_F_TX]
      && !i_func_out[`PXB_F_TX] && pin_input_mode_ff[`PXB_P_TX])
      |=> !o_pin_oe_n[`PXB_P_TX] && !o_pin_out[`PXB_P_TX];
  endproperty
  a_uart_fixed: assert property (p_uart_fixed) else $error("uart tx not on fixed pin");

  property p_first_free;
    (!pin_skip_mask_ff[0] && route_select_low_ff[`PXB_B_SPI]) |-> a_fn[0] == `PXB_F_SCK;
  endproperty
  a_first_free: assert property (p_first_free) else $error("spi clock not on lowest pin");

  property p_skip;
    pin_skip_mask_ff[0] |-> !a_vld[0];
  endproperty
  a_skip: assert property (p_skip) else $error("skipped pin allocated");

  property p_xbar_off;
    !router_enable ##1 !router_enable |-> &o_pin_oe_n;
  endproperty
  a_xbar_off: assert property (p_xbar_off) else $error("driver on while crossbar off");

  property p_analog;
    !pin_input_mode_ff[0] |=> !o_pullup_en[0] && o_pin_oe_n[0] && o_pin_analog[0];
  endproperty
  a_analog: assert property (p_analog) else $error("analog pin not isolated");

  property p_pud;
    pullup_disable |=> o_pullup_en == '0;
  endproperty
  a_pud: assert property (p_pud) else $error("pullup while disabled");

  property p_pushpull_nopu;
    (pin_output_mode_ff[1] && !is_i2c[1]) |=> !o_pullup_en[1];
  endproperty
  a_pushpull_nopu: assert property (p_pushpull_nopu) else $error("pullup on push-pull");

  property p_i2c_od;
    |(i2c_ff & ~o_pin_oe_n & o_pin_out) == 1'b0;
  endproperty
  a_i2c_od: assert property (p_i2c_od) else $error("smbus pin driven high");

  property p_nss_3wire;
    (slave_select_mode_ff == `PXB_SSM_3WIRE) |-> !fen[`PXB_F_NSS];
  endproperty
  a_nss_3wire: assert property (p_nss_3wire) else $error("nss routed in 3-wire");

  property p_apb_ready;
    (i_psel && i_penable && !o_pready) |=> o_pready ##1 !o_pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("apb ready timing");

  property p_skip_write;
    (wr_take && i_paddr == `PXB_A_SKIP) |=> pin_skip_mask_ff == $past(i_pwdata[23:0]);
  endproperty
  a_skip_write: assert property (p_skip_write) else $error("skip write lost");

  c_uart_spi: cover property (router_enable && fen[`PXB_F_TX] && fen[`PXB_F_SCK]);
  c_skip_used: cover property (router_enable && |(pin_skip_mask_ff & ~taken) == 1'b0);
  c_read: cover property (o_pready && !i_pwrite && !o_pslverr);
  c_i2c_low: cover property (|(i2c_ff & ~o_pin_oe_n));

endmodule

// ==== bench/pxb_board.sv ====
/*
 * Board model at the crossbar pads: design drive wins, then external drive,
 * then the weak pullup; a floating pad toggles. Assumes pxb_pkg types.
 */
`timescale 1ns/1ps
module pxb_board
  import pxb_pkg::*;
(
  input wire logic i_ref_clk,
  input wire pxb_pins_t i_pin_out,
  input wire pxb_pins_t i_pin_oe_n,
  input wire pxb_pins_t i_pullup_en,
  input wire pxb_pins_t i_ext_en,
  input wire pxb_pins_t i_ext_val,
  output pxb_pins_t o_pad
);
  // floating pads keep moving so a stale level never passes a read
  pxb_pins_t float_ff = 24'h5a5a5a;
  always_ff @(posedge i_ref_clk)
  begin
    float_ff <= ~float_ff;
  end
  always_comb
  begin
    for (int i = 0; i < 24; i++)
    begin
      o_pad[i] = !i_pin_oe_n[i] ? i_pin_out[i] : i_ext_en[i] ? i_ext_val[i] :
                 i_pullup_en[i] ? 1'b1 : float_ff[i];
    end
  end
endmodule

// ==== bench/testbench.sv ====
/*
 * Self-checking bench for the port crossbar: APB master, random routing.
 * Assumes pxb_crossbar, pxb_board and pxb_pkg are compiled first.
 */
`timescale 1ns/1ps
module testbench
  import pxb_pkg::*;
;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
  logic [7:0] pa = 8'h00;
  logic [31:0] pwd = 32'h0, rdv, prd;
  logic erv, pslv, prdy;
  logic [7:0] c_rsl, c_rsh;
  logic [1:0] c_ssm;
  pxb_pins_t pad, p_out, p_oen, p_pu, p_an, ext_en = '0, ext_val = '0;
  pxb_pins_t c_lat, c_in, c_out, c_skip, e_out, e_oen, e_pu, e_port, m_port;
  pxb_funcs_t fo = '0, foe = '0, f_in, e_fin, m_fin;
  int err_total = 0, num_checks = 0, pin_fn [24];
  logic [31:0] rst_exp [7] = '{32'h0, 32'h0, 32'hffffff, 32'hffffff, 32'h0, 32'h0, 32'h0};
  initial forever #5 clk = ~clk;
  pxb_crossbar i_dut (.i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(pen),
    .i_pwrite(pwr), .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy),
    .o_pslverr(pslv), .i_pin_in(pad), .o_pin_out(p_out), .o_pin_oe_n(p_oen),
    .o_pullup_en(p_pu), .o_pin_analog(p_an), .i_func_out(fo), .i_func_oe(foe),
    .o_func_in(f_in));
  pxb_board i_board (.i_ref_clk(clk), .i_pin_out(p_out), .i_pin_oe_n(p_oen),
    .i_pullup_en(p_pu), .i_ext_en(ext_en), .i_ext_val(ext_val), .o_pad(pad));
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    num_checks++;
    if ((got & m) !== (exp & m))
    begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got & m, exp & m);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pen <= 0;
    pwr <= wr;
    pa <= a;
    pwd <= wd;
    @(posedge clk);
    pen <= 1;
    // ready, data and error are all taken at the rising edge itself
    @(posedge clk);
    while (prdy !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (prdy !== 1'b1)
    begin
      err_total++;
      finish_test();
    end
    rdv = prd;
    erv = pslv;
    psel <= 0;
    pen <= 0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic fen(input int f);
    if (f <= 4) return c_rsl[1];
    if (f == 5) return c_rsl[1] && c_ssm != 2'h0; // four-wire only
    if (f <= 7) return c_rsl[2]; // both bus lines
    if (f <= 11) return c_rsl[f - 4];
    if (f == 12) return c_rsl[3];
    if (f <= 18) return c_rsh[2:0] != 3'h7 && (f - 13) < c_rsh[2:0];
    return c_rsh[f - 16];
  endfunction
  function automatic void alloc();
    pxb_pins_t used;
    int p;
    used = c_skip; // skipped pins count as taken
    p = 0;
    for (int i = 0; i < 24; i++) pin_fn[i] = -1;
    if (c_rsl[0])
    begin
      pin_fn[4] = 0; // fixed serial pins
      pin_fn[5] = 1;
      used[5:4] = 2'h3;
    end
    for (int f = 2; f < 22; f++)
      if (fen(f))
      begin
        while (p < 24 && used[p]) p++; // lowest free pin
        if (p < 24) pin_fn[p] = f;
        if (p < 24) used[p] = 1'b1;
      end
  endfunction
  function automatic void expect_all(input logic xb);
    int f;
    logic od, drv, val, pu, kn, lv;
    e_out = '0;
    e_oen = '1;
    e_pu = '0;
    e_port = '0;
    m_port = '1;
    e_fin = '1;
    m_fin = '1;
    alloc();
    for (int i = 0; i < 24; i++)
    begin
      f = pin_fn[i];
      od = !c_out[i] || f == 6 || f == 7;
      drv = 1'b0;
      val = c_lat[i];
      if (xb && c_in[i] && f >= 0)
      begin
        drv = foe[f] && (!od || !fo[f]);
        val = fo[f];
      end
      else if (xb && c_in[i])
        drv = !od || !val; // plain port I/O
      pu = !c_rsh[7] && od && c_in[i] && !(drv && !val);
      kn = drv || ext_en[i] || pu;
      lv = drv ? val : ext_en[i] ? ext_val[i] : 1'b1;
      e_out[i] = drv && val;
      e_oen[i] = !drv;
      e_pu[i] = pu;
      e_port[i] = c_in[i] && lv;
      m_port[i] = kn || !c_in[i];
      if (xb && f >= 0) e_fin[f] = c_in[i] && lv;
      if (xb && f >= 0) m_fin[f] = kn || !c_in[i];
    end
  endfunction
  task automatic check_all(input logic xb);
    expect_all(xb);
    chk(p_oen, e_oen, '1); // drivers per crossbar state
    chk(p_out, e_out, '1);
    chk(p_pu, e_pu, '1);
    chk(p_an, {8'h0, ~c_in}, '1);
    chk(f_in, e_fin, m_fin);
    apb(0, 8'h08, 32'h0);
    chk(rdv, e_port, {8'hff, m_port}); // live pin level
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(62722));
    repeat (2) @(posedge clk);
    rst <= 0;
    repeat (2) @(posedge clk);
    chk(p_oen, 32'hffffff, '1); // digital inputs
    chk(p_pu, 32'hffffff, '1);
    for (int i = 0; i < 7; i++)
    begin
      apb(0, 8'(i * 4), 32'h0);
      chk(rdv, rst_exp[i], '1);
    end
    apb(0, 8'h1c, 32'h0);
    chk({erv, rdv[30:0]}, 32'h80000000, '1); // unmapped read refused
    for (int it = 0; it < 12; it++)
    begin
      c_in = ~($urandom & $urandom) | 24'h000030;
      c_out = $urandom;
      c_lat = $urandom | ~c_in; // analog pins latch one
      c_skip = ($urandom & $urandom) | ~c_in; // analog pins skipped
      c_rsl = $urandom;
      c_rsh = {$urandom % 2 == 1, 1'b0, 3'($urandom), 3'($urandom % 8)};
      c_ssm = $urandom;
      if (it == 0) {c_in, c_skip, c_rsl, c_rsh, c_ssm} = {24'hffffff, 24'h0, 8'hff, 8'h3e, 2'h1};
      // reference and conversion-start pins skipped
      if (it == 1) {c_skip, c_rsl, c_rsh, c_ssm} = {24'h000450 | ~c_in, 8'h03, 8'h0f, 2'h0};
      if (it == 2) {c_rsl, c_rsh} = 16'h0;
      @(posedge clk);
      fo <= $urandom;
      foe <= $urandom | $urandom;
      ext_en <= $urandom & $urandom;
      ext_val <= $urandom;
      // setup order mirrors the required software sequence
      apb(1, 8'h0c, 32'(c_in));
      apb(1, 8'h10, 32'(c_out));
      apb(1, 8'h08, 32'(c_lat));
      apb(1, 8'h14, 32'(c_skip));
      apb(1, 8'h18, 32'(c_ssm));
      apb(1, 8'h00, 32'(c_rsl));
      apb(1, 8'h04, 32'(c_rsh));
      repeat (8) @(posedge clk);
      check_all(1'b0); // routing ignored while disabled
      apb(1, 8'h04, 32'(c_rsh | 8'h40));
      repeat (8) @(posedge clk);
      check_all(1'b1); // fresh allocation each pass
    end
    finish_test();
  end
endmodule
